// ---- verilog/angle_settings_pkg.sv ----
/*
 * Package for the angle sensor settings block: register indices, field positions,
 * reset values, field threshold tables and the packed carriers.
 * Assumes a single system clock and an 8-bit register write/read port.
 */
package angle_settings_pkg;

    // ************************************************************
    // Register indices (byte wide registers)
    // ************************************************************
    localparam logic [4:0] REG_ZERO_LO      = 5'h00;
    localparam logic [4:0] REG_ZERO_HI      = 5'h01;
    localparam logic [4:0] REG_BIAS_TRIM    = 5'h02;
    localparam logic [4:0] REG_TRIM_ENABLE  = 5'h03;
    localparam logic [4:0] REG_FIELD_THRESH = 5'h06;
    localparam logic [4:0] REG_DIRECTION    = 5'h09;
    localparam logic [4:0] REG_FIELD_FLAGS  = 5'h1B;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TRIM_X_BIT      = 0;
    localparam int TRIM_Y_BIT      = 1;
    localparam int DETECT_EN_BIT   = 0;
    localparam int HIGH_THR_LSB    = 2;
    localparam int LOW_THR_LSB     = 5;
    localparam int DIRECTION_BIT   = 7;
    localparam int HIGH_FLAG_BIT   = 7;
    localparam int LOW_FLAG_BIT    = 6;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_ZERO_LO      = 8'h00;
    localparam logic [7:0]  RST_ZERO_HI      = 8'h00;
    localparam logic [7:0]  RST_BIAS_TRIM    = 8'h00;
    localparam logic [1:0]  RST_TRIM_ENABLE  = 2'h0;
    localparam logic [7:0]  RST_FIELD_THRESH = 8'h1D;
    localparam logic        RST_DIRECTION    = 1'b0;

    // ************************************************************
    // Field thresholds in mT, rising and falling trip points
    // ************************************************************
    localparam logic [7:0] FIELD_RISE_MT [8] = '{8'h1A, 8'h29, 8'h38, 8'h46,
                                                 8'h54, 8'h62, 8'h70, 8'h7E};
    localparam logic [7:0] FIELD_FALL_MT [8] = '{8'h14, 8'h23, 8'h32, 8'h40,
                                                 8'h4E, 8'h5C, 8'h6A, 8'h78};

    typedef struct packed {
        logic [15:0] zero_offset;
        logic [7:0]  bias_trim;
        logic        trim_x_enable;
        logic        trim_y_enable;
        logic [2:0]  field_low_threshold;
        logic [2:0]  field_high_threshold;
        logic        field_detect_enable;
        logic        direction_ccw;
    } settings_s;

    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage : angle_settings_pkg

// ---- verilog/angle_sensor_settings.sv ----
/*
 * Settings and post-processing of a magnetic angle sensor: zero offset, direction,
 * bias trim outputs toward the Hall front end and field-strength flags with hysteresis.
 * Assumes the serial front end decodes commands into a one-cycle register request on
 * the system clock, and that the raw angle and field magnitude come from same-clock logic.
 */

// Functional notes
// RULE1: The output angle is the raw angle minus a 16-bit zero offset.
// RULE2: The zero offset code spans one full turn, 360/65536 degrees per step.
// RULE3: Direction bit 0 counts up clockwise, 1 counts up counterclockwise.
// RULE4: An 8-bit bias trim sets the sensitivity reduction, zero meaning none.
// RULE5: Two axis enables choose the trimmed axis, both set trims both equally.
// RULE6: Each axis enable bit turns trimming off at 0 and on at 1.
// RULE7: Field measurement runs only while the detect enable bit is 1.
// RULE8: Low flag when field is below the low threshold, high flag when above the high one.
// RULE9: Both 3-bit thresholds sit in register 6, low above high.
// RULE10: Both flags use hysteresis, the falling trip below the rising one.
// RULE11: Flags read at bits 7 and 6 of register 27, low flag also on a pin.
// RULE12: The offset subtraction wraps modulo 65536.
module angle_sensor_settings (
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    input  wire angle_settings_pkg::reg_req_s i_reg_req,
    input  wire logic [15:0]                 i_raw_angle,
    input  wire logic [7:0]                  i_field_mt,
    output logic [15:0]                      o_angle,
    output logic [7:0]                       o_reg_rdata,
    output logic [7:0]                       o_trim_x,
    output logic [7:0]                       o_trim_y,
    output logic                             o_field_low_pin,
    output logic                             o_field_high
);
    import angle_settings_pkg::*;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    settings_s cfg_ff;
    settings_s nxt_cfg;

    // Writes to unmapped or read-only indices fall to the default arm and leave every
    // setting untouched, so a stray write to the flag register cannot disturb anything.
    always_comb begin
        nxt_cfg = cfg_ff;
        if (i_reg_req.we) begin
            unique case (i_reg_req.addr)
                REG_ZERO_LO:      nxt_cfg.zero_offset[7:0]  = i_reg_req.wdata;
                REG_ZERO_HI:      nxt_cfg.zero_offset[15:8] = i_reg_req.wdata;
                REG_BIAS_TRIM:    nxt_cfg.bias_trim = i_reg_req.wdata; // see RULE4
                REG_TRIM_ENABLE: begin
                    nxt_cfg.trim_x_enable = i_reg_req.wdata[TRIM_X_BIT];
                    nxt_cfg.trim_y_enable = i_reg_req.wdata[TRIM_Y_BIT];
                end
                REG_FIELD_THRESH: begin // see RULE9
                    nxt_cfg.field_low_threshold  = i_reg_req.wdata[LOW_THR_LSB +: 3];
                    nxt_cfg.field_high_threshold = i_reg_req.wdata[HIGH_THR_LSB +: 3];
                    nxt_cfg.field_detect_enable  = i_reg_req.wdata[DETECT_EN_BIT];
                end
                REG_DIRECTION:    nxt_cfg.direction_ccw = i_reg_req.wdata[DIRECTION_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cfg_ff.zero_offset          <= {RST_ZERO_HI, RST_ZERO_LO};
            cfg_ff.bias_trim            <= RST_BIAS_TRIM;
            cfg_ff.trim_x_enable        <= RST_TRIM_ENABLE[TRIM_X_BIT];
            cfg_ff.trim_y_enable        <= RST_TRIM_ENABLE[TRIM_Y_BIT];
            cfg_ff.field_low_threshold  <= RST_FIELD_THRESH[LOW_THR_LSB +: 3];
            cfg_ff.field_high_threshold <= RST_FIELD_THRESH[HIGH_THR_LSB +: 3];
            cfg_ff.field_detect_enable  <= RST_FIELD_THRESH[DETECT_EN_BIT];
            cfg_ff.direction_ccw        <= RST_DIRECTION;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ************************************************************
    // Angle path
    // ************************************************************
    logic [15:0] angle_ff;
    logic [15:0] nxt_angle;
    logic [15:0] offset_angle;

    always_comb begin
        // The 16-bit difference wraps naturally, so any code maps onto one turn.
        offset_angle = i_raw_angle - cfg_ff.zero_offset; // see RULE1, RULE2, RULE12
        // Mirroring the angle inverts the counting sense; zero stays at zero.
        nxt_angle = cfg_ff.direction_ccw ? 16'(16'h0000 - offset_angle)
                                         : offset_angle; // see RULE3
    end

    // An offset change moves the output at the next edge with no settling, so a host that
    // writes the two offset bytes one by one sees one mixed value between the writes.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            angle_ff <= 16'h0000;
        end else begin
            angle_ff <= nxt_angle;
        end
    end

    // ************************************************************
    // Bias trim outputs
    // ************************************************************
    logic [7:0]  trim_x_ff;
    logic [7:0]  nxt_trim_x;
    logic [7:0]  trim_y_ff;
    logic [7:0]  nxt_trim_y;

    // Only the trim code leaves the block; how far it lowers the Hall bias is up to the
    // analog front end. Both axes enabled gives equal trims and no side-shaft correction.
    always_comb begin
        nxt_trim_x = cfg_ff.trim_x_enable ? cfg_ff.bias_trim : 8'h00; // see RULE5, RULE6
        nxt_trim_y = cfg_ff.trim_y_enable ? cfg_ff.bias_trim : 8'h00; // see RULE5, RULE6
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            trim_x_ff <= 8'h00;
            trim_y_ff <= 8'h00;
        end else begin
            trim_x_ff <= nxt_trim_x;
            trim_y_ff <= nxt_trim_y;
        end
    end

    // ************************************************************
    // Field-strength flags
    // ************************************************************
    logic        low_ff;
    logic        nxt_low;
    logic        high_ff;
    logic        nxt_high;

    // Trip point of one threshold code, picked by whether the flag is already raised.
    function automatic logic [7:0] trip_mt(input logic [2:0] code, input logic falling);
        trip_mt = falling ? FIELD_FALL_MT[code] : FIELD_RISE_MT[code];
    endfunction

    always_comb begin
        nxt_low  = 1'b0;
        nxt_high = 1'b0;
        if (cfg_ff.field_detect_enable) begin // see RULE7
            // A raised low flag clears only once the field rises to the rising trip or above.
            if (low_ff) begin
                nxt_low = i_field_mt < trip_mt(cfg_ff.field_low_threshold, 1'b0); // see RULE10
            end else begin
                nxt_low = i_field_mt < trip_mt(cfg_ff.field_low_threshold, 1'b1); // see RULE8
            end
            if (high_ff) begin
                nxt_high = i_field_mt > trip_mt(cfg_ff.field_high_threshold, 1'b1); // see RULE10
            end else begin
                nxt_high = i_field_mt > trip_mt(cfg_ff.field_high_threshold, 1'b0); // see RULE8
            end
        end
    end

    // Both flags leave reset low, so the first enabled comparison uses the setting trips:
    // a field inside a hysteresis band at that moment stays unflagged.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            low_ff  <= 1'b0;
            high_ff <= 1'b0;
        end else begin
            low_ff  <= nxt_low;
            high_ff <= nxt_high;
        end
    end

    // ************************************************************
    // Register read-back
    // ************************************************************
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;

    // Read data follows the address every cycle, so a host polling one index sees each
    // update one cycle late; unmapped indices read as zero.
    always_comb begin
        unique case (i_reg_req.addr)
            REG_ZERO_LO:      nxt_rdata = cfg_ff.zero_offset[7:0];
            REG_ZERO_HI:      nxt_rdata = cfg_ff.zero_offset[15:8];
            REG_BIAS_TRIM:    nxt_rdata = cfg_ff.bias_trim;
            REG_TRIM_ENABLE:  nxt_rdata = {6'h00, cfg_ff.trim_y_enable, cfg_ff.trim_x_enable};
            REG_FIELD_THRESH: nxt_rdata = {cfg_ff.field_low_threshold,
                                           cfg_ff.field_high_threshold,
                                           1'b0, cfg_ff.field_detect_enable};
            REG_DIRECTION:    nxt_rdata = {cfg_ff.direction_ccw, 7'h00};
            REG_FIELD_FLAGS:  nxt_rdata = {high_ff, low_ff, 6'h00}; // see RULE11
            default:          nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output is a flip-flop, so the pins never show decode glitches.
    assign o_angle         = angle_ff;
    assign o_reg_rdata     = rdata_ff;
    assign o_trim_x        = trim_x_ff;
    assign o_trim_y        = trim_y_ff;
    assign o_field_low_pin = low_ff; // see RULE11
    assign o_field_high    = high_ff;

endmodule // angle_sensor_settings

// ---- testbench/angle_sensor_settings_asserts.sv ----
/* Checker for the angle sensor settings block, watching its ports only.
   Assumes it is bound to the top module and that reset is asynchronous, active high. */
module angle_sensor_settings_asserts import angle_settings_pkg::*; (
    input wire logic                         i_clock,
    input wire logic                         i_rst,
    input wire angle_settings_pkg::reg_req_s i_reg_req,
    input wire logic [15:0]                  i_raw_angle,
    input wire logic [7:0]                   i_field_mt,
    input wire logic [15:0]                  o_angle,
    input wire logic [7:0]                   o_reg_rdata,
    input wire logic [7:0]                   o_trim_x,
    input wire logic [7:0]                   o_trim_y,
    input wire logic                         o_field_low_pin,
    input wire logic                         o_field_high
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************
    // Quiet-cycle counter
    // ********************
    // The angle step check needs history free of writes, since offset or direction writes move the angle.
    logic [2:0] quiet_ff;
    logic [2:0] nxt_quiet;
    wire logic       wr = i_reg_req.we;
    wire logic [4:0] ad = i_reg_req.addr;
    always_comb nxt_quiet = wr ? 3'h0 : ((quiet_ff == 3'h7) ? quiet_ff : quiet_ff + 3'h1);
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) quiet_ff <= 3'h0;
        else quiet_ff <= nxt_quiet;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    angle_step_a: assert property (
        quiet_ff > 3'h3 |-> (16'(o_angle - $past(o_angle)) == 16'($past(i_raw_angle) - $past(i_raw_angle, 2)))
        || (16'($past(o_angle) - o_angle) == 16'($past(i_raw_angle) - $past(i_raw_angle, 2))))
        else $error("angle step does not follow raw step");
    x_off_a: assert property (wr && ad == REG_TRIM_ENABLE && !i_reg_req.wdata[0] |-> ##2 o_trim_x == 8'h00)
        else $error("x trim not zero when disabled");
    y_off_a: assert property (wr && ad == REG_TRIM_ENABLE && !i_reg_req.wdata[1] |-> ##2 o_trim_y == 8'h00)
        else $error("y trim not zero when disabled");
    both_equal_a: assert property (wr && ad == REG_TRIM_ENABLE && i_reg_req.wdata[1:0] == 2'h3 |-> ##2 o_trim_x == o_trim_y)
        else $error("trims differ with both axes enabled");
    detect_off_a: assert property (wr && ad == REG_FIELD_THRESH && !i_reg_req.wdata[0] |-> ##2 !o_field_low_pin && !o_field_high)
        else $error("field flag set while detection disabled");
    high_field_a: assert property (o_field_high |-> $past(i_field_mt) > 8'h14)
        else $error("high flag kept at low field");
    low_field_a: assert property (o_field_low_pin |-> $past(i_field_mt) < 8'h7E)
        else $error("low flag kept at high field");
    flag_read_a: assert property (ad == REG_FIELD_FLAGS |=> o_reg_rdata == {$past(o_field_high), $past(o_field_low_pin), 6'h00})
        else $error("flag register layout wrong");
    reserved_zero_a: assert property (ad == REG_TRIM_ENABLE |=> o_reg_rdata[7:2] == 6'h00)
        else $error("enable register upper bits not zero");
    cover property (o_field_high && o_field_low_pin);
    cover property (wr && ad == REG_DIRECTION);
    cover property (o_trim_x != 8'h00 && o_trim_y == 8'h00);
endmodule // angle_sensor_settings_asserts

// ---- testbench/host_model.sv ----
/* Host controller model issuing register writes and reads on the request port.
   Assumes read data is registered one cycle after the address is applied. */
module host_model import angle_settings_pkg::*; (
    input  wire logic [7:0]                  i_rdata,
    input  wire logic                        i_clock,
    output angle_settings_pkg::reg_req_s     o_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_req = '{1'b0, 5'h1F, 8'h00};
    // Write data is inverted once released, so stale data never looks valid.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1 o_req = '{1'b1, a, d};
        @(posedge i_clock);
        #1 o_req = '{1'b0, a, ~d};
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clock);
        #1 o_req.addr = a;
        @(posedge i_clock);
        #1 d = i_rdata;
    endtask
endmodule // host_model

// ---- testbench/angle_sensor_settings_tb_top.sv ----
/* Self-checking bench for the angle sensor settings block, driven through the host model.
   Assumes inputs change 1 ns after each rising edge. */
module angle_sensor_settings_tb_top import angle_settings_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic [15:0] i_raw_angle = 16'h0010;
    logic [7:0]  i_field_mt = 8'h3C;
    reg_req_s    i_reg_req;
    logic [15:0] o_angle;
    logic [7:0]  o_reg_rdata, o_trim_x, o_trim_y, rv;
    logic        o_field_low_pin, o_field_high;
    logic [7:0]  fv [5] = '{8'h2D, 8'h37, 8'h38, 8'h24, 8'h23};
    logic [4:0]  fl = 5'h1B;
    logic [4:0]  fh = 5'h0F;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;
    always #5 i_clock = ~i_clock;
    angle_sensor_settings angle_sensor_settings_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_reg_req(i_reg_req), .i_raw_angle(i_raw_angle), .i_field_mt(i_field_mt),
        .o_angle(o_angle), .o_reg_rdata(o_reg_rdata), .o_trim_x(o_trim_x),
        .o_trim_y(o_trim_y), .o_field_low_pin(o_field_low_pin), .o_field_high(o_field_high));
    host_model host_model_i (.i_rdata(o_reg_rdata), .i_clock(i_clock), .o_req(i_reg_req));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_clock) if (++cycles == 2000) begin
        mismatches++;
        tally_and_finish();
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        host_model_i.rd(a, rv);
        chk("rdata", {8'h00, exp}, {8'h00, rv});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    initial begin
        cyc(2);
        i_rst = 1'b0;
        rchk(REG_ZERO_LO, RST_ZERO_LO);
        rchk(REG_ZERO_HI, RST_ZERO_HI);
        rchk(REG_BIAS_TRIM, RST_BIAS_TRIM);
        rchk(REG_TRIM_ENABLE, {6'h00, RST_TRIM_ENABLE});
        rchk(REG_FIELD_THRESH, RST_FIELD_THRESH);
        rchk(REG_DIRECTION, {RST_DIRECTION, 7'h00});
        host_model_i.wr(REG_FIELD_FLAGS, 8'hFF);
        rchk(REG_FIELD_FLAGS, 8'h00);
        host_model_i.wr(REG_ZERO_LO, 8'h20);
        cyc(2);
        chk("angle", 16'hFFF0, o_angle);
        host_model_i.wr(REG_ZERO_HI, 8'h80);
        cyc(2);
        chk("angle", 16'h7FF0, o_angle);
        host_model_i.wr(REG_DIRECTION, 8'h80);
        // A ramp of raw angles shows counting in the opposite sense.
        repeat (5) begin
            cyc(1);
            i_raw_angle = i_raw_angle + 16'h0101;
        end
        cyc(2);
        chk("angle", 16'(16'h8020 - i_raw_angle), o_angle);
        host_model_i.wr(REG_BIAS_TRIM, 8'hA5);
        for (int e = 0; e < 4; e++) begin
            host_model_i.wr(REG_TRIM_ENABLE, 8'(e));
            cyc(2);
            chk("trim_x", e[0] ? 16'h00A5 : 16'h0000, {8'h00, o_trim_x});
            chk("trim_y", e[1] ? 16'h00A5 : 16'h0000, {8'h00, o_trim_y});
        end
        host_model_i.wr(REG_FIELD_THRESH, 8'h45);
        for (int k = 0; k < 5; k++) begin
            i_field_mt = fv[k];
            cyc(2);
            chk("low_pin", {15'h0000, fl[k]}, {15'h0000, o_field_low_pin});
            chk("high", {15'h0000, fh[k]}, {15'h0000, o_field_high});
            rchk(REG_FIELD_FLAGS, {fh[k], fl[k], 6'h00});
        end
        host_model_i.wr(REG_FIELD_THRESH, 8'h44);
        cyc(2);
        chk("flags", 16'h0000, {14'h0000, o_field_high, o_field_low_pin});
        host_model_i.wr(REG_FIELD_THRESH, 8'h45);
        cyc(2);
        chk("flags", 16'h0001, {14'h0000, o_field_high, o_field_low_pin});
        tally_and_finish();
    end
endmodule // angle_sensor_settings_tb_top
bind angle_sensor_settings angle_sensor_settings_asserts angle_sensor_settings_asserts_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_req(i_reg_req), .i_raw_angle(i_raw_angle),
    .i_field_mt(i_field_mt), .o_angle(o_angle), .o_reg_rdata(o_reg_rdata), .o_trim_x(o_trim_x),
    .o_trim_y(o_trim_y), .o_field_low_pin(o_field_low_pin), .o_field_high(o_field_high));
